/* File: rtl/tmps_regs.svh */
// register offsets, field positions, reset values and timing counts of the temperature sequencer
`ifndef TMPS_REGS_SVH
`define TMPS_REGS_SVH

// ****************************************************
// register byte offsets
// ****************************************************
`define TMPS_CFG01_OFF 12'h004
`define TMPS_CFG08_OFF 12'h020
`define TMPS_CFG09_OFF 12'h024
`define TMPS_CFG14_OFF 12'h038
`define TMPS_CTRL_OFF 12'h100
`define TMPS_STAT_OFF 12'h104
`define TMPS_MEAS_OFF 12'h108
`define TMPS_RES245_OFF 12'h3D4
`define TMPS_CORR_OFF 12'h3D8

// ****************************************************
// field positions
// ****************************************************
`define TMPS_CFG01_CORR_BIT 6
`define TMPS_CFG01_TEMP_BIT 8
`define TMPS_CFG14_SEL_BIT 0
`define TMPS_CTRL_START_BIT 0
`define TMPS_FRAC_BITS 20

// ****************************************************
// reset values and timing
// ****************************************************
`define TMPS_CFG_RST 24'h000000
`define TMPS_DIS_NS 2000
`define TMPS_CLK_NS 25
`define TMPS_DIS_CYC ((`TMPS_DIS_NS + `TMPS_CLK_NS - 1) / `TMPS_CLK_NS)

`endif

/* File: rtl/tmps_pkg.sv */
// types shared by the temperature sequencer modules
package tmps_pkg;
    typedef enum logic [2:0] {
        TMPS_IDLE,
        TMPS_MAIN,
        TMPS_REF,
        TMPS_SER,
        TMPS_DIV,
        TMPS_PUB
    } tmps_state_e;
    typedef logic [23:0] tmps_word_t;
endpackage : tmps_pkg

/* File: rtl/tmps_div.sv */
// sequential unsigned divider forming a fixed point quotient
`timescale 1ns/10ps
`include "tmps_regs.svh"
module tmps_div
    import tmps_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // operands
    input wire logic start,
    input wire logic [31:0] num,
    input wire logic [31:0] den,
    // result
    output logic busy,
    output logic done,
    output logic [31:0] quot
);
    logic [63:0] rem_r, rem_nxt;
    logic [31:0] q_r, q_nxt;
    logic [31:0] d_r, d_nxt;
    logic [5:0] cnt_r, cnt_nxt;
    logic busy_r, busy_nxt;
    logic done_r, done_nxt;
    logic [63:0] trial;

    // restoring division, one quotient bit per clock
    always_comb begin
        rem_nxt = rem_r;
        q_nxt = q_r;
        d_nxt = d_r;
        cnt_nxt = cnt_r;
        busy_nxt = busy_r;
        done_nxt = 1'b0;
        trial = {rem_r[62:0], 1'b0};
        if (start && !busy_r) begin
            rem_nxt = {32'h00000000, num};
            d_nxt = den;
            q_nxt = 32'h00000000;
            cnt_nxt = 6'h20;
            busy_nxt = 1'b1;
        end else if (busy_r) begin
            if (trial[63:32] >= d_r) begin
                rem_nxt = {trial[63:32] - d_r, trial[31:0]};
                q_nxt = {q_r[30:0], 1'b1};
            end else begin
                rem_nxt = trial;
                q_nxt = {q_r[30:0], 1'b0};
            end
            cnt_nxt = cnt_r - 6'h01;
            if (cnt_r == 6'h01) begin
                busy_nxt = 1'b0;
                done_nxt = 1'b1;
            end
        end
    end

    // state registers
    always_ff @(posedge clk) begin
        if (!rstn) begin
            rem_r <= 64'h0000000000000000;
            q_r <= 32'h00000000;
            d_r <= 32'h00000000;
            cnt_r <= 6'h00;
            busy_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            rem_r <= rem_nxt;
            q_r <= q_nxt;
            d_r <= d_nxt;
            cnt_r <= cnt_nxt;
            busy_r <= busy_nxt;
            done_r <= done_nxt;
        end
    end

    assign busy = busy_r;
    assign done = done_r;
    assign quot = q_r;
endmodule : tmps_div

/* File: rtl/tmps_tdc.sv */
// discharge time counter: counts clocks until the comparator trips
`timescale 1ns/10ps
`include "tmps_regs.svh"
module tmps_tdc
    import tmps_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // control
    input wire logic start,
    input wire logic comp_trip,
    // result
    output logic done,
    output logic [23:0] count
);
    logic run_r, run_nxt;
    logic done_r, done_nxt;
    logic [23:0] cnt_r, cnt_nxt;

    // count from start until comparator trip, saturating
    always_comb begin
        run_nxt = run_r;
        done_nxt = 1'b0;
        cnt_nxt = cnt_r;
        if (start && !run_r) begin
            run_nxt = 1'b1;
            cnt_nxt = 24'h000001;
        end else if (run_r) begin
            if (comp_trip) begin
                run_nxt = 1'b0;
                done_nxt = 1'b1;
            end else if (cnt_r != 24'hFFFFFF) begin
                cnt_nxt = cnt_r + 24'h000001;
            end
        end
    end

    // state registers
    always_ff @(posedge clk) begin
        if (!rstn) begin
            run_r <= 1'b0;
            done_r <= 1'b0;
            cnt_r <= 24'h000000;
        end else begin
            run_r <= run_nxt;
            done_r <= done_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    assign done = done_r;
    assign count = cnt_r;
endmodule : tmps_tdc

/* File: rtl/tmps_seq.sv */
// on-chip temperature ratio sequencer with apb registers
`timescale 1ns/10ps
`include "tmps_regs.svh"
module tmps_seq
    import tmps_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // analog front end
    input wire logic comp_trip,
    output logic discharge_en,
    output logic bridge_port_c2_gauge_sw,
    output logic bridge_port_d1_gauge_sw,
    output logic bridge_port_c2_sense_sw,
    output logic bridge_port_d1_sense_sw,
    output logic sense_resistor_value_select,
    // status
    output logic meas_busy
);
    // ****************************************************
    // registers
    // ****************************************************
    tmps_word_t cfg01_r, cfg01_nxt;
    tmps_word_t gain_drift_factor_r, gain_drift_factor_nxt;
    tmps_word_t offset_drift_factor_r, offset_drift_factor_nxt;
    tmps_word_t cfg14_r, cfg14_nxt;
    tmps_word_t main_r, main_nxt;
    tmps_word_t ref_r, ref_nxt;
    tmps_word_t ser_r, ser_nxt;
    tmps_word_t res245_r, res245_nxt;
    logic [31:0] corr_r, corr_nxt;
    tmps_word_t main_pub_r, main_pub_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic pslverr_r, pslverr_nxt;
    logic [15:0] cycles_r, cycles_nxt;
    tmps_state_e state_r, state_nxt;
    logic start_req;
    logic tdc_start;
    logic tdc_done;
    logic [23:0] tdc_count;
    logic div_start;
    logic div_done;
    logic [31:0] div_quot;
    logic [31:0] div_num;
    logic [31:0] ratio_frac;
    logic [63:0] corr_prod;
    logic wr_acc;
    logic rd_acc;

    assign wr_acc = psel && penable && pwrite;
    assign rd_acc = psel && penable && !pwrite;
    assign start_req = wr_acc && (paddr == `TMPS_CTRL_OFF) && pwdata[`TMPS_CTRL_START_BIT];

    // address decode for the error response of reads and writes; read data and writes decode separately
    function automatic logic addr_known(input logic [11:0] a);
        if (a == `TMPS_CFG01_OFF) addr_known = 1'b1;
        else if (a == `TMPS_CFG08_OFF) addr_known = 1'b1;
        else if (a == `TMPS_CFG09_OFF) addr_known = 1'b1;
        else if (a == `TMPS_CFG14_OFF) addr_known = 1'b1;
        else if (a == `TMPS_CTRL_OFF) addr_known = 1'b1;
        else if (a == `TMPS_STAT_OFF) addr_known = 1'b1;
        else if (a == `TMPS_MEAS_OFF) addr_known = 1'b1;
        else if (a == `TMPS_RES245_OFF) addr_known = 1'b1;
        else if (a == `TMPS_CORR_OFF) addr_known = 1'b1;
        else addr_known = 1'b0;
    endfunction : addr_known

    // ****************************************************
    // sub blocks
    // ****************************************************
    tmps_tdc u_tdc (
        .clk(clk),
        .rstn(rstn),
        .start(tdc_start),
        .comp_trip(comp_trip),
        .done(tdc_done),
        .count(tdc_count)
    );

    // ratio sense/gauge = (ser - ref)/ref for a series pair, scaled 2^20
    // numerator taken from the live series count, since ser_r loads on the start edge
    // limitation: count differences above 12 bits wrap in the numerator
    assign div_num = 32'({tdc_count - ref_r, 20'h00000});
    tmps_div u_div (
        .clk(clk),
        .rstn(rstn),
        .start(div_start),
        .num(div_num),
        .den({8'h00, ref_r}),
        .busy(),
        .done(div_done),
        .quot(div_quot)
    );
    assign ratio_frac = div_quot;

    // ****************************************************
    // measurement sequencer
    // ****************************************************
    always_comb begin
        state_nxt = state_r;
        main_nxt = main_r;
        ref_nxt = ref_r;
        ser_nxt = ser_r;
        res245_nxt = res245_r;
        main_pub_nxt = main_pub_r;
        corr_nxt = corr_r;
        cycles_nxt = cycles_r;
        tdc_start = 1'b0;
        div_start = 1'b0;
        corr_prod = 64'h0000000000000000;
        case (state_r)
            TMPS_IDLE: begin
                if (start_req) begin
                    state_nxt = TMPS_MAIN;
                    tdc_start = 1'b1;
                end
            end
            TMPS_MAIN: begin
                if (tdc_done) begin
                    main_nxt = tdc_count;
                    if (cfg01_r[`TMPS_CFG01_TEMP_BIT]) begin
                        state_nxt = TMPS_REF;
                        tdc_start = 1'b1;
                    end else begin
                        state_nxt = TMPS_PUB;
                    end
                end
            end
            TMPS_REF: begin
                if (tdc_done) begin
                    ref_nxt = tdc_count;
                    state_nxt = TMPS_SER;
                    tdc_start = 1'b1;
                end
            end
            TMPS_SER: begin
                if (tdc_done) begin
                    ser_nxt = tdc_count;
                    state_nxt = TMPS_DIV;
                    div_start = 1'b1;
                end
            end
            TMPS_DIV: begin
                if (div_done) begin
                    state_nxt = TMPS_PUB;
                end
            end
            default: begin
                // publish everything at once at cycle end
                main_pub_nxt = main_r;
                if (cfg01_r[`TMPS_CFG01_TEMP_BIT]) begin
                    res245_nxt = ratio_frac[23:0];
                end
                if (cfg01_r[`TMPS_CFG01_CORR_BIT]) begin
                    corr_prod = 64'(gain_drift_factor_r) * 64'(res245_nxt);
                    corr_nxt = corr_prod[51:20] + 32'(offset_drift_factor_r);
                end else begin
                    corr_nxt = 32'h00000000;
                end
                cycles_nxt = cycles_r + 16'h0001;
                state_nxt = TMPS_IDLE;
            end
        endcase
    end

    // analog switch control per phase
    always_comb begin
        discharge_en = (state_r == TMPS_MAIN) || (state_r == TMPS_REF) || (state_r == TMPS_SER);
        bridge_port_c2_gauge_sw = (state_r == TMPS_REF) || (state_r == TMPS_SER);
        bridge_port_d1_gauge_sw = (state_r == TMPS_REF) || (state_r == TMPS_SER);
        bridge_port_c2_sense_sw = (state_r == TMPS_SER);
        bridge_port_d1_sense_sw = (state_r == TMPS_SER);
    end
    assign sense_resistor_value_select = cfg14_r[`TMPS_CFG14_SEL_BIT];
    assign meas_busy = (state_r != TMPS_IDLE);

    // ****************************************************
    // apb register access
    // ****************************************************
    always_comb begin
        cfg01_nxt = cfg01_r;
        gain_drift_factor_nxt = gain_drift_factor_r;
        offset_drift_factor_nxt = offset_drift_factor_r;
        cfg14_nxt = cfg14_r;
        prdata_nxt = prdata_r;
        pslverr_nxt = 1'b0;
        if (psel && !penable) begin
            pslverr_nxt = !addr_known(paddr);
            if (paddr == `TMPS_CFG01_OFF) prdata_nxt = {8'h00, cfg01_r};
            else if (paddr == `TMPS_CFG08_OFF) prdata_nxt = {8'h00, gain_drift_factor_r};
            else if (paddr == `TMPS_CFG09_OFF) prdata_nxt = {8'h00, offset_drift_factor_r};
            else if (paddr == `TMPS_CFG14_OFF) prdata_nxt = {8'h00, cfg14_r};
            else if (paddr == `TMPS_STAT_OFF) prdata_nxt = {15'h0000, meas_busy, cycles_r};
            else if (paddr == `TMPS_MEAS_OFF) prdata_nxt = {8'h00, main_pub_r};
            else if (paddr == `TMPS_RES245_OFF) prdata_nxt = {8'h00, res245_r};
            else if (paddr == `TMPS_CORR_OFF) prdata_nxt = corr_r;
            else prdata_nxt = 32'h00000000;
        end
        if (wr_acc) begin
            if (paddr == `TMPS_CFG01_OFF) cfg01_nxt = pwdata[23:0];
            else if (paddr == `TMPS_CFG08_OFF) gain_drift_factor_nxt = pwdata[23:0];
            else if (paddr == `TMPS_CFG09_OFF) offset_drift_factor_nxt = pwdata[23:0];
            else if (paddr == `TMPS_CFG14_OFF) cfg14_nxt = pwdata[23:0];
        end
    end

    assign pready = psel && penable;
    assign prdata = prdata_r;
    assign pslverr = pslverr_r && psel && penable;

    // ****************************************************
    // state registers
    // ****************************************************
    always_ff @(posedge clk) begin
        if (!rstn) begin
            cfg01_r <= `TMPS_CFG_RST;
            gain_drift_factor_r <= `TMPS_CFG_RST;
            offset_drift_factor_r <= `TMPS_CFG_RST;
            cfg14_r <= `TMPS_CFG_RST;
            main_r <= 24'h000000;
            ref_r <= 24'h000000;
            ser_r <= 24'h000000;
            res245_r <= 24'h000000;
            corr_r <= 32'h00000000;
            main_pub_r <= 24'h000000;
            prdata_r <= 32'h00000000;
            pslverr_r <= 1'b0;
            cycles_r <= 16'h0000;
            state_r <= TMPS_IDLE;
        end else begin
            cfg01_r <= cfg01_nxt;
            gain_drift_factor_r <= gain_drift_factor_nxt;
            offset_drift_factor_r <= offset_drift_factor_nxt;
            cfg14_r <= cfg14_nxt;
            main_r <= main_nxt;
            ref_r <= ref_nxt;
            ser_r <= ser_nxt;
            res245_r <= res245_nxt;
            corr_r <= corr_nxt;
            main_pub_r <= main_pub_nxt;
            prdata_r <= prdata_nxt;
            pslverr_r <= pslverr_nxt;
            cycles_r <= cycles_nxt;
            state_r <= state_nxt;
        end
    end
endmodule : tmps_seq

/* File: verif/tmps_seq_sva.sv */
// port assertions for the temperature ratio sequencer
`timescale 1ns/10ps
`include "tmps_regs.svh"
module tmps_seq_chk
    import tmps_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // analog front end
    input wire logic comp_trip,
    input wire logic discharge_en,
    input wire logic bridge_port_c2_gauge_sw,
    input wire logic bridge_port_d1_gauge_sw,
    input wire logic bridge_port_c2_sense_sw,
    input wire logic bridge_port_d1_sense_sw,
    input wire logic sense_resistor_value_select,
    // status
    input wire logic meas_busy
);
    logic temp_en_r;
    logic temp_en_nxt;
    logic wr_go;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // ****************************************************
    // shadow of the temperature enable bit
    // ****************************************************
    assign wr_go = psel && penable && pwrite;
    always_comb begin
        temp_en_nxt = temp_en_r;
        if (wr_go && paddr == `TMPS_CFG01_OFF) begin
            temp_en_nxt = pwdata[`TMPS_CFG01_TEMP_BIT];
        end
    end
    always_ff @(posedge clk) begin
        if (!rstn) begin
            temp_en_r <= 1'b0;
        end else begin
            temp_en_r <= temp_en_nxt;
        end
    end
    // ****************************************************
    // assertions and covers
    // ****************************************************
    temp_gate_a: assert property ($rose(bridge_port_c2_gauge_sw) |-> temp_en_r)
        else $error("gauge switch closed with temperature disabled");
    sel_write_a: assert property (wr_go && paddr == `TMPS_CFG14_OFF
        |=> sense_resistor_value_select == $past(pwdata[`TMPS_CFG14_SEL_BIT]))
        else $error("resistor select does not follow cfg14");
    sense_pair_a: assert property (bridge_port_c2_sense_sw == bridge_port_d1_sense_sw)
        else $error("sense switches differ");
    gauge_pair_a: assert property (bridge_port_c2_gauge_sw == bridge_port_d1_gauge_sw)
        else $error("gauge switches differ");
    ref_first_a: assert property ($rose(bridge_port_c2_sense_sw) |->
        $past(bridge_port_c2_gauge_sw) && !$past(bridge_port_c2_sense_sw))
        else $error("series cycle not preceded by reference cycle");
    sw_dis_a: assert property (bridge_port_c2_gauge_sw |-> discharge_en && meas_busy)
        else $error("port switch closed outside a discharge");
    once_only_a: assert property ($fell(bridge_port_c2_sense_sw) |->
        (!bridge_port_c2_gauge_sw && !discharge_en) [*8])
        else $error("extra discharge after temperature cycles");
    pub_end_a: assert property ($fell(bridge_port_c2_sense_sw) |->
        meas_busy ##[30:45] !meas_busy)
        else $error("publish not at end of cycle");
    idle_off_a: assert property (!meas_busy |-> !discharge_en)
        else $error("discharge while idle");
    apb_ready_a: assert property (pready == (psel && penable))
        else $error("pready not in first access cycle");
    map_err_a: assert property (psel && penable && paddr == `TMPS_RES245_OFF |-> !pslverr)
        else $error("result location refused");
    cov_ser_c: cover property ($rose(bridge_port_c2_sense_sw));
    cov_done_c: cover property ($fell(meas_busy));
    cov_err_c: cover property (pslverr);
endmodule : tmps_seq_chk
bind tmps_seq tmps_seq_chk u_chk (.clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .comp_trip, .discharge_en, .bridge_port_c2_gauge_sw,
    .bridge_port_d1_gauge_sw, .bridge_port_c2_sense_sw, .bridge_port_d1_sense_sw,
    .sense_resistor_value_select, .meas_busy);

/* File: verif/tb_onchip_temp_ratio_sequencer.sv */
// self-checking bench for the temperature ratio sequencer
`timescale 1ns/10ps
`include "tmps_regs.svh"
module tb_onchip_temp_ratio_sequencer
    import tmps_pkg::*;
;
    logic clk, rstn, psel, penable, pwrite, pready, pslverr, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q, r;
    logic comp_trip = 1'b0;
    logic discharge_en, bridge_port_c2_gauge_sw, bridge_port_d1_gauge_sw;
    logic bridge_port_c2_sense_sw, bridge_port_d1_sense_sw, sense_resistor_value_select;
    logic meas_busy;
    logic [2:0] ph, ph_q;
    int cnt, gcnt, ref_dly, ser_dly, compares, miscompares;
    tmps_seq uut (.clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .comp_trip, .discharge_en, .bridge_port_c2_gauge_sw, .bridge_port_d1_gauge_sw,
        .bridge_port_c2_sense_sw, .bridge_port_d1_sense_sw, .sense_resistor_value_select,
        .meas_busy);
    // ****************************************************
    // clock, comparator model and switch monitor
    // ****************************************************
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    assign ph = {discharge_en, bridge_port_c2_gauge_sw, bridge_port_c2_sense_sw};
    // comparator trips once per phase after a phase dependent delay
    always @(posedge clk) begin
        ph_q <= ph;
        cnt <= (ph != ph_q) ? 0 : cnt + 1;
        comp_trip <= ph[2] && (cnt == (ph[0] ? ser_dly : ph[1] ? ref_dly : 20));
        if (bridge_port_c2_gauge_sw === 1'b1) gcnt <= gcnt + 1;
    end
    // ****************************************************
    // bus and check tasks
    // ****************************************************
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic chk(input string n, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s exp %h got %h", n, exp, got);
        end
    endtask : chk
    task automatic rdchk(input string n, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(n, exp, q);
    endtask : rdchk
    // result within a small slack of the ideal ratio
    task automatic near(input string n, input logic [31:0] exp);
        apb(1'b0, `TMPS_RES245_OFF, 32'h0);
        r = q;
        compares++;
        if ($isunknown(q) || q > exp + (exp >> 5) || q + (exp >> 5) < exp) begin
            miscompares++;
            $display("[ERR] %s exp %h got %h", n, exp, q);
        end
    endtask : near
    // starts a cycle with the given discharge delays
    task automatic go(input int rd_d, input int sr_d);
        ref_dly = rd_d;
        ser_dly = sr_d;
        apb(1'b1, `TMPS_CTRL_OFF, 32'h1);
    endtask : go
    task automatic fin();
        repeat (2) @(posedge clk);
        while (meas_busy === 1'b1) @(posedge clk);
    endtask : fin
    task automatic wrap_up();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : wrap_up
    // ****************************************************
    // test sequence and watchdog
    // ****************************************************
    initial begin
        #(25 * 30000);
        miscompares++;
        wrap_up();
    end
    initial begin
        {rstn, psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        rdchk("cfg01", `TMPS_CFG01_OFF, 32'h0);
        rdchk("res245", `TMPS_RES245_OFF, 32'h0);
        rdchk("unmapped", 12'h200, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, e});
        apb(1'b1, `TMPS_CFG14_OFF, 32'h1);
        @(negedge clk);
        chk("sel 300", 32'h1, {31'h0, sense_resistor_value_select});
        apb(1'b1, `TMPS_CFG14_OFF, 32'h0);
        @(negedge clk);
        chk("sel 600", 32'h0, {31'h0, sense_resistor_value_select});
        go(200, 400);
        fin();
        chk("no temp cycles", 32'h0, gcnt);
        rdchk("res245 off", `TMPS_RES245_OFF, 32'h0);
        apb(1'b1, `TMPS_CFG01_OFF, 32'h100);
        go(200, 400);
        rdchk("res245 mid", `TMPS_RES245_OFF, 32'h0);
        apb(1'b1, `TMPS_CTRL_OFF, 32'h1);
        fin();
        chk("temp cycles seen", 32'h1, {31'h0, gcnt > 0});
        near("ratio one", 32'h100000);
        rdchk("stat", `TMPS_STAT_OFF, 32'h2);
        rdchk("corr off", `TMPS_CORR_OFF, 32'h0);
        go(200, 300);
        fin();
        near("ratio half", 32'h080000);
        apb(1'b1, `TMPS_RES245_OFF, 32'h0);
        rdchk("res245 hold", `TMPS_RES245_OFF, r);
        apb(1'b1, `TMPS_CFG08_OFF, 32'h100000);
        apb(1'b1, `TMPS_CFG09_OFF, 32'h10);
        rdchk("cfg08", `TMPS_CFG08_OFF, 32'h100000);
        apb(1'b1, `TMPS_CFG01_OFF, 32'h140);
        go(200, 400);
        fin();
        near("ratio corr", 32'h100000);
        rdchk("corr on", `TMPS_CORR_OFF, (r + 32'h10) & 32'hFFFFFF);
        rdchk("stat end", `TMPS_STAT_OFF, 32'h4);
        wrap_up();
    end
endmodule : tb_onchip_temp_ratio_sequencer
